// File: dv/hrs_board_model.sv
// board side: reset pin source and configuration straps
`timescale 1ns/1ps
`include "hrs_cfg.svh"
module hrs_board_model (
    // clock
    input  wire logic                   clk_sys,
    // reset pin
    input  wire logic                   reset_pin_out,
    input  wire logic                   reset_pin_oe_n,
    input  wire logic                   board_drive_low,
    output logic                        reset_in_n,
    // straps
    input  wire logic                   cfg_pullup_en,
    input  wire logic [`HRS_PORT_W-1:0] strap_pd,
    output logic [`HRS_PORT_W-1:0]      startup_config_port
);
    logic flt_q = 1'b0;
    always_ff @(posedge clk_sys) flt_q <= ~flt_q;
    assign reset_in_n = (reset_pin_oe_n | reset_pin_out) & ~board_drive_low;
    assign startup_config_port = ~strap_pd & (cfg_pullup_en ? 16'hFFFF : {16{flt_q}});
endmodule : hrs_board_model

// File: dv/hrs_hardware_reset_sequencer_bench.sv
// testbench of the hardware reset sequencer
`timescale 1ns/1ps
`include "hrs_cfg.svh"
module hrs_hardware_reset_sequencer_bench;
    logic clk_sys, nrst, drv, eoi, busy, ioreq, rin_n, r_out, r_oe_n, rst_out_n, pu, hc, crn;
    logic fs, ale, boe_n, io_en;
    logic [15:0] pd, port;
    logic [23:0] fa;
    hrs_pkg::hrs_startup_cfg_t cfg;
    int failures = 0, cmp_count = 0, n;
    hrs_hardware_reset_sequencer u_hrs_hardware_reset_sequencer (.clk_sys(clk_sys),
        .nrst(nrst), .reset_in_n(rin_n), .reset_pin_out(r_out), .reset_pin_oe_n(r_oe_n),
        .reset_out_n(rst_out_n), .startup_config_port(port), .cfg_pullup_en(pu),
        .startup_cfg(cfg), .end_of_init_instruction(eoi), .bus_cycle_busy(busy),
        .io_enable_req(ioreq), .hold_cancel(hc), .core_reset_n(crn), .fetch_start(fs),
        .fetch_addr(fa), .ale_first(ale), .bus_oe_n(boe_n), .io_enable(io_en));
    hrs_board_model u_hrs_board_model (.clk_sys(clk_sys), .reset_pin_out(r_out),
        .reset_pin_oe_n(r_oe_n), .board_drive_low(drv), .reset_in_n(rin_n),
        .cfg_pullup_en(pu), .strap_pd(pd), .startup_config_port(port));
    task end_sim;
        $display("comparisons %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : end_sim
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            failures++;
            $display("Error t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task tick; @(posedge clk_sys); #1; n++; endtask : tick
    task end_init;
        @(posedge clk_sys) eoi <= 1'b1;
        @(posedge clk_sys) eoi <= 1'b0;
        #1 chk(rst_out_n, 1);
    endtask : end_init
    task wait_ale;
        for (n = 0; n < 1500 && ale !== 1'b1; ) tick();
        chk({fs, ale, fa}, {2'b11, 24'h000000});
        chk(cfg, {~pd[0], ~pd[1], ~pd[15:13]});
        chk({rst_out_n, io_en}, 0);
    endtask : wait_ale
    task powerup;
        repeat (20) @(posedge clk_sys);
        eoi <= 1'b1;
        @(posedge clk_sys) eoi <= 1'b0;
        repeat (6) @(posedge clk_sys);
        drv <= 1'b0;
        wait_ale();
        end_init();
        @(posedge clk_sys) ioreq <= 1'b1;
        @(posedge clk_sys) ioreq <= 1'b0;
        #1 chk(io_en, 1);
    endtask : powerup
    task warm(input int extra, input logic [15:0] straps, input logic bsy);
        @(posedge clk_sys) begin pd <= straps; busy <= bsy; drv <= 1'b1; end
        #20 chk({boe_n, crn}, 2'b10);
        for (n = 0; n < 20 && r_oe_n !== 1'b0; ) tick();
        chk(n >= `HRS_START_MIN_HALF / `HRS_HALF_PER_CYC && n <= `HRS_START_MAX_CYC, 1);
        @(posedge clk_sys) drv <= (extra > 0);
        #1 for (n = 1; n < 600 && r_oe_n === 1'b0; ) tick();
        chk(n, `HRS_SEQ_CYC);
        if (extra > 0) begin
            repeat (extra) @(posedge clk_sys);
            chk(crn, 0);
            @(posedge clk_sys) drv <= 1'b0;
        end
        for (n = 0; n < 10 && crn !== 1'b1; ) tick();
        chk(n >= 2 && n <= 3, 1);
        busy <= 1'b0;
        wait_ale();
        chk(n, `HRS_ALE_CYC);
        end_init();
    endtask : warm
    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end
    initial begin
        repeat (5000) @(posedge clk_sys);
        failures++;
        end_sim();
    end
    initial begin
        {eoi, busy, ioreq} = 3'b000;
        pd = 16'h0001;
        // pin held 33 cycles at power-up
        drv = 1'b1;
        nrst = 1'b0;
        repeat (6) @(posedge clk_sys);
        nrst <= 1'b1;
        powerup();
        warm(0, 16'hA002, 1'b1);
        warm(20, 16'h4001, 1'b0);
        end_sim();
    end
endmodule : hrs_hardware_reset_sequencer_bench

// File: dv/hrs_seq_chk.sv
// assertions on the reset sequencer ports
`timescale 1ns/1ps
`include "hrs_cfg.svh"
module hrs_seq_chk (
    // clock and reset
    input wire logic                      clk_sys,
    input wire logic                      nrst,
    // reset pins
    input wire logic                      reset_in_n,
    input wire logic                      reset_pin_out,
    input wire logic                      reset_pin_oe_n,
    input wire logic                      reset_out_n,
    // start-up configuration
    input wire logic                      cfg_pullup_en,
    input wire logic [`HRS_PORT_W-1:0]    startup_config_port,
    input wire hrs_pkg::hrs_startup_cfg_t startup_cfg,
    // core side
    input wire logic                      end_of_init_instruction,
    input wire logic                      bus_cycle_busy,
    input wire logic                      io_enable_req,
    input wire logic                      hold_cancel,
    input wire logic                      core_reset_n,
    input wire logic                      fetch_start,
    input wire logic                      ale_first,
    input wire logic                      bus_oe_n,
    input wire logic                      io_enable,
    input wire logic [`HRS_ADDR_W-1:0]    fetch_addr
);
    logic [9:0]             oe_cnt_q;
    logic [`HRS_PORT_W-1:0] port_q;
    always_ff @(posedge clk_sys or negedge nrst)
        if (!nrst) oe_cnt_q <= 10'h000;
        else oe_cnt_q <= reset_pin_oe_n ? 10'h000 : oe_cnt_q + 10'h001;
    // port value of the previous cycle, for the load check
    always_ff @(posedge clk_sys or negedge nrst)
        if (!nrst) port_q <= '0;
        else port_q <= startup_config_port;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!nrst);
    a_seq_len: assert property ($rose(reset_pin_oe_n) |-> oe_cnt_q == 10'h200)
        else $error("pin pull length wrong");
    a_pin_pull: assert property (!reset_pin_oe_n |-> !reset_pin_out && !core_reset_n)
        else $error("pin not pulled low");
    a_seq_start: assert property (
        $fell(reset_in_n) && $past(core_reset_n) |-> ##[2:8] !reset_pin_oe_n)
        else $error("sequence start out of window");
    a_end_win: assert property (
        $rose(reset_in_n) && !hold_cancel && reset_pin_oe_n && !core_reset_n
        |-> ##[1:3] core_reset_n) else $error("reset end late");
    a_low_holds: assert property (!reset_in_n |-> !core_reset_n && bus_oe_n)
        else $error("bus or core active with pin low");
    a_ale_gap: assert property (
        $rose(core_reset_n) |-> !ale_first[*4] ##1 (ale_first && fetch_start
        && fetch_addr == `HRS_FETCH_ADDR)) else $error("first strobe gap");
    a_cfg_load: assert property (
        !reset_pin_oe_n && !$past(reset_pin_oe_n) |-> cfg_pullup_en && startup_cfg
        == {port_q[`HRS_EMUL_BIT], port_q[`HRS_ISO_BIT],
        port_q[`HRS_CLKCFG_MSB:`HRS_CLKCFG_LSB]})
        else $error("configuration not loaded");
    a_reset_out_gate: assert property (
        $rose(reset_out_n) |-> $past(end_of_init_instruction))
        else $error("reset output released early");
    a_hold_cancel: assert property ($fell(reset_pin_oe_n) |-> $past(hold_cancel))
        else $error("hold not cancelled");
    a_io_gate: assert property ($rose(io_enable) |-> $past(io_enable_req))
        else $error("io enabled without request");
    c_seq: cover property ($rose(reset_pin_oe_n));
    c_ale: cover property (ale_first);
    c_io: cover property ($rose(io_enable));
endmodule : hrs_seq_chk
bind hrs_hardware_reset_sequencer hrs_seq_chk u_hrs_seq_chk (.*);

// File: rtl/hrs_cfg.svh
// timing counts and field positions of the hardware reset sequencer
`ifndef HRS_CFG_SVH
`define HRS_CFG_SVH

// clock rate and half clock periods per cycle
`define HRS_CLK_PERIOD_NS   50
`define HRS_HALF_PER_CYC    2

// warm reset start window after the pin falls, in half clock periods
`define HRS_START_MIN_HALF  4
`define HRS_START_MAX_HALF  16
`define HRS_START_MAX_CYC   (`HRS_START_MAX_HALF / `HRS_HALF_PER_CYC)

// synchroniser depth in cycles
`define HRS_SYNC_CYC        2

// longest stay in the wait state before the sequence must start
`define HRS_WAIT_MAX_CYC    (`HRS_START_MAX_CYC - `HRS_SYNC_CYC - 2)

// fixed internal reset sequence
`define HRS_SEQ_HALF        1024
`define HRS_SEQ_CYC         (`HRS_SEQ_HALF / `HRS_HALF_PER_CYC)

// end of reset condition to the first address latch strobe
`define HRS_ALE_HALF        8
`define HRS_ALE_CYC         (`HRS_ALE_HALF / `HRS_HALF_PER_CYC)

// counter width, covers the sequence length
`define HRS_CNT_W           10

// start-up configuration port layout
`define HRS_PORT_W          16
`define HRS_EMUL_BIT        0
`define HRS_ISO_BIT         1
`define HRS_CLKCFG_LSB      13
`define HRS_CLKCFG_MSB      15

// first fetch address
`define HRS_ADDR_W          24
`define HRS_FETCH_ADDR      24'h000000

`endif

// File: rtl/hrs_hardware_reset_sequencer.sv
// hardware reset sequencer: warm and power-up reset, start-up latch, reset output
`timescale 1ns/1ps
`include "hrs_cfg.svh"

// Operation
// RL1: warm reset pin low 4 half-periods plus 10ns
// RL2: sequence starts 4 to 16 half-periods after fall
// RL3: sequence lasts 1024 half-periods, pin driven low
// RL4: reset ends 4 to 6 half-periods after rise
// RL5: config bits loaded continuously during internal reset
// RL6: first address strobe 8 half-periods after end
// RL7: power-up reset input low at least 1500ns
// RL8: bus released within 50ns of input fall
// RL9: asynchronous reset forces default state immediately
// RL10: power-up reset held until clock and straps settle
// RL11: configuration pull-ups enabled during reset
// RL12: fetch starts at address zero after reset
// RL13: reset output held until end-of-init instruction
// RL14: io pins inactive until software enables them
// RL15: cancel holds, finish access before warm reset; code waits at most 5 cycles for busy
// RL16: reset ends only when input high after sequence
// RL17: two half-periods per cycle, sequence 512 cycles
// RL18: two-stage synchroniser plus asynchronous forcing path
module hrs_hardware_reset_sequencer (
    // clock and power-up reset
    input  wire logic                          clk_sys,
    input  wire logic                          nrst,
    // reset pin, open drain
    input  wire logic                          reset_in_n,
    output logic                               reset_pin_out,
    output logic                               reset_pin_oe_n,
    // reset output pin
    output logic                               reset_out_n,
    // start-up configuration port
    input  wire logic [`HRS_PORT_W-1:0]        startup_config_port,
    output logic                               cfg_pullup_en,
    output hrs_pkg::hrs_startup_cfg_t          startup_cfg,
    // core side
    input  wire logic                          end_of_init_instruction,
    input  wire logic                          bus_cycle_busy,
    input  wire logic                          io_enable_req,
    output logic                               hold_cancel,
    output logic                               core_reset_n,
    output logic                               fetch_start,
    output logic [`HRS_ADDR_W-1:0]             fetch_addr,
    output logic                               ale_first,
    output logic                               bus_oe_n,
    output logic                               io_enable
);

    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    localparam logic [`HRS_CNT_W-1:0] SEQ_LAST  = `HRS_CNT_W'(`HRS_SEQ_CYC - 1);
    localparam logic [`HRS_CNT_W-1:0] WAIT_LAST = `HRS_CNT_W'(`HRS_WAIT_MAX_CYC);
    localparam logic [`HRS_CNT_W-1:0] ALE_LAST  = `HRS_CNT_W'(`HRS_ALE_CYC - 1);

    logic                      sync1_q;
    logic                      sync2_q;
    hrs_pkg::hrs_state_t       state_q;
    hrs_pkg::hrs_state_t       state_d;
    logic [`HRS_CNT_W-1:0]     cnt_q;
    logic                      in_reset;
    logic                      bus_drive_q;
    logic                      reset_out_q;
    logic                      io_en_q;
    logic                      fetch_q;
    logic                      ale_q;
    hrs_pkg::hrs_startup_cfg_t cfg_q;

    // ------------------------------------------------------------
    // reset pin synchroniser
    // ------------------------------------------------------------
    // RL18: two flip-flop synchroniser
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            sync1_q <= 1'b0;
            sync2_q <= 1'b0;
        end else begin
            sync1_q <= reset_in_n;
            sync2_q <= sync1_q;
        end
    end

    // ------------------------------------------------------------
    // sequence state machine
    // ------------------------------------------------------------
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            hrs_pkg::HRS_ST_RUN,
            hrs_pkg::HRS_ST_ALE: begin
                // RL2: fall seen after the synchroniser
                if (!sync2_q) begin
                    state_d = hrs_pkg::HRS_ST_WAIT;
                end else if (state_q == hrs_pkg::HRS_ST_ALE && cnt_q == ALE_LAST) begin
                    state_d = hrs_pkg::HRS_ST_RUN;
                end
            end
            hrs_pkg::HRS_ST_WAIT: begin
                // RL15: let running access finish, bounded wait
                if (!bus_cycle_busy || cnt_q == WAIT_LAST) begin
                    state_d = hrs_pkg::HRS_ST_SEQ;
                end
            end
            hrs_pkg::HRS_ST_SEQ: begin
                // RL17: 512 cycles of sequence
                if (cnt_q == SEQ_LAST) begin
                    state_d = hrs_pkg::HRS_ST_WAITHI;
                end
            end
            hrs_pkg::HRS_ST_WAITHI: begin
                // RL16: end only once the pin reads high
                if (sync2_q) begin
                    state_d = hrs_pkg::HRS_ST_ALE;
                end
            end
            default: begin
                state_d = hrs_pkg::HRS_ST_WAIT;
            end
        endcase
    end

    // RL9: power-up reset starts in the default state
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            state_q <= hrs_pkg::HRS_ST_WAIT;
        end else begin
            state_q <= state_d;
        end
    end

    // RL3: interval counter, cleared on each state change
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            cnt_q <= '0;
        end else if (state_d != state_q) begin
            cnt_q <= '0;
        end else if (cnt_q != {`HRS_CNT_W{1'b1}}) begin
            cnt_q <= cnt_q + `HRS_CNT_W'(1);
        end
    end

    assign in_reset = (state_q == hrs_pkg::HRS_ST_SEQ) || (state_q == hrs_pkg::HRS_ST_WAITHI);

    // ------------------------------------------------------------
    // pins and core controls
    // ------------------------------------------------------------
    // RL3: pull own reset pin low during sequence
    assign reset_pin_out  = 1'b0;
    assign reset_pin_oe_n = (state_q != hrs_pkg::HRS_ST_SEQ);

    // RL15: pending holds cancelled before reset
    assign hold_cancel = (state_q == hrs_pkg::HRS_ST_WAIT);

    // RL9: pin low forces core reset without a clock
    assign core_reset_n = reset_in_n && nrst && !in_reset && (state_q != hrs_pkg::HRS_ST_WAIT);

    // RL11: pull-ups on the configuration lines
    assign cfg_pullup_en = in_reset || (state_q == hrs_pkg::HRS_ST_WAIT);

    // RL8: bus released combinationally on pin low
    assign bus_oe_n = !bus_drive_q || !reset_in_n;

    // RL4: bus driven again at reset condition end
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            bus_drive_q <= 1'b0;
        end else if (state_d == hrs_pkg::HRS_ST_ALE && state_q == hrs_pkg::HRS_ST_WAITHI) begin
            bus_drive_q <= 1'b1;
        end else if (state_d == hrs_pkg::HRS_ST_WAIT) begin
            bus_drive_q <= 1'b0;
        end
    end

    // RL6: first strobe and fetch 8 half-periods after end
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            ale_q   <= 1'b0;
            fetch_q <= 1'b0;
        end else begin
            ale_q   <= (state_q == hrs_pkg::HRS_ST_ALE) && (cnt_q == ALE_LAST) && sync2_q;
            fetch_q <= (state_q == hrs_pkg::HRS_ST_ALE) && (cnt_q == ALE_LAST) && sync2_q;
        end
    end

    assign ale_first   = ale_q;
    assign fetch_start = fetch_q;
    // RL12: execution begins at address zero
    assign fetch_addr  = `HRS_FETCH_ADDR;

    // RL13: reset output held until end-of-init
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            reset_out_q <= 1'b0;
        end else if (state_q != hrs_pkg::HRS_ST_RUN) begin
            reset_out_q <= 1'b0;
        end else if (end_of_init_instruction) begin
            reset_out_q <= 1'b1;
        end
    end

    assign reset_out_n = reset_out_q;

    // RL14: io pins off until software enables them
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            io_en_q <= 1'b0;
        end else if (state_q != hrs_pkg::HRS_ST_RUN) begin
            io_en_q <= 1'b0;
        end else if (io_enable_req) begin
            io_en_q <= 1'b1;
        end
    end

    assign io_enable = io_en_q;

    // ------------------------------------------------------------
    // start-up configuration latch
    // ------------------------------------------------------------
    // RL5: registered load every cycle while internal reset active
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            cfg_q <= '0;
        end else if (in_reset) begin
            cfg_q.emulation_config_bit <= startup_config_port[`HRS_EMUL_BIT];
            cfg_q.isolation_config_bit <= startup_config_port[`HRS_ISO_BIT];
            cfg_q.clock_config <= startup_config_port[`HRS_CLKCFG_MSB:`HRS_CLKCFG_LSB];
        end
    end

    assign startup_cfg = cfg_q;

endmodule : hrs_hardware_reset_sequencer

// File: rtl/hrs_pkg.sv
// types of the hardware reset sequencer
package hrs_pkg;

    typedef enum logic [2:0] {
        HRS_ST_WAIT   = 3'b000,
        HRS_ST_SEQ    = 3'b001,
        HRS_ST_WAITHI = 3'b010,
        HRS_ST_ALE    = 3'b011,
        HRS_ST_RUN    = 3'b100
    } hrs_state_t;

    typedef struct packed {
        logic       emulation_config_bit;
        logic       isolation_config_bit;
        logic [2:0] clock_config;
    } hrs_startup_cfg_t;

endpackage : hrs_pkg
